// file: hdl/srs_pkg.sv
// constants, state layout and types of the reset status and option block
package srs_pkg;
   // register indices on the cpu register port
   localparam logic [1:0] IDX_STATUS = 2'h0;
   localparam logic [1:0] IDX_FORCE  = 2'h1;
   localparam logic [1:0] IDX_OPT1   = 2'h2;
   localparam logic [1:0] IDX_OPT2   = 2'h3;
   // reset cause status bit positions
   localparam int ST_POR  = 7;
   localparam int ST_PIN  = 6;
   localparam int ST_WDG  = 5;
   localparam int ST_ILLEGAL_OPCODE_FLAG = 4;
   localparam int ST_ILLEGAL_ADDRESS_FLAG = 3;
   localparam int ST_LVD  = 1;
   // first options register fields
   localparam int O1_TMO_LO = 6;
   localparam int O1_STOP   = 5;
   localparam int O1_TWI    = 2;
   localparam logic [7:0] O1_MASK = 8'hE4;
   // second options register fields
   localparam int O2_CLK  = 7;
   localparam int O2_WIN  = 6;
   localparam int O2_COMPARATOR_CAPTURE_ROUTE = 4;
   localparam logic [7:0] O2_MASK = 8'hDF;
   localparam logic [7:0] O2_ONCE = 8'hC0;
   // values after reset
   localparam logic [7:0] STATUS_POR = 8'h82;
   localparam logic [7:0] OPT1_RST   = 8'h00;
   localparam logic [7:0] OPT2_RST   = 8'h00;
   // watchdog service values and force bit
   localparam logic [7:0] SVC_FIRST  = 8'h55;
   localparam logic [7:0] SVC_SECOND = 8'hAA;
   localparam int FORCE_BIT = 0;
   // least reset hold time
   localparam int CLK_NS   = 4;
   localparam int HOLD_NS  = 64;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   // sequencer phase
   typedef enum logic [0:0] {SRS_RUN, SRS_HOLD} srs_phase_t;
   // whole state of the block
   typedef struct packed {
      srs_phase_t phase;
      logic [7:0] hold_cnt;
      logic       lv_hold;
      logic [7:0] status;
      logic [7:0] opt1;
      logic       opt1_lock;
      logic [7:0] opt2;
      logic       opt2_lock;
      logic       armed;
      logic       warn;
      logic       irq;
      logic       trip;
      logic       stop_go;
      logic       wdog_clr;
      logic       sys_rst;
      logic [7:0] rdata;
   } srs_state_t;
endpackage

// file: hdl/srs_reset_status.sv
// reset sequencer, reset cause status, watchdog service and system options
`timescale 1ns/1ps
module srs_reset_status #(
   parameter int HOLD_W = 8
) (
   // clock and power-on reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // cpu register port
   input  wire logic [1:0] cpu_sel,
   input  wire logic       cpu_wr,
   input  wire logic       cpu_rd,
   input  wire logic [7:0] cpu_wdata,
   output logic      [7:0] cpu_rdata,
   // background debug write to the force register
   input  wire logic       dbg_wr,
   input  wire logic [7:0] dbg_wdata,
   // reset sources
   input  wire logic       rst_pin_n,
   input  wire logic       lvd_detect,
   input  wire logic       lvd_above,
   input  wire logic       illegal_opcode,
   input  wire logic       illegal_addr,
   input  wire logic       stop_exec,
   // low-voltage control from power management
   input  wire logic       lowvolt_reset_enable,
   input  wire logic       lowvolt_trip_select,
   input  wire logic       lowvolt_warn_irq_enable,
   input  wire logic       lvw_detect,
   input  wire logic       warn_ack,
   // watchdog counter status
   input  wire logic       watchdog_enable_bit,
   input  wire logic       wdog_timeout,
   input  wire logic       wdog_late,
   // reset, watchdog and warning outputs
   output logic            sys_reset,
   output logic            wdog_clear,
   output logic            lvd_trip_sel,
   output logic            lowvolt_warn_flag,
   output logic            lowvolt_warn_irq,
   output logic            stop_enter,
   // option outputs
   output logic      [1:0] watchdog_timeout_field,
   output logic            stop_allow_bit,
   output logic            twowire_pin_select,
   output logic            watchdog_clock_select,
   output logic            watchdog_window_bit,
   output logic            comparator_capture_route,
   output logic      [3:0] timer_pin_select
);

   // elaboration check: the hold counter in the state is eight bits wide
   if (HOLD_W < 2 || HOLD_W > 8 || srs_pkg::HOLD_CYC >= (1 << HOLD_W)) begin : g_hold_check
      $error("HOLD_W does not fit the reset hold count");
   end

   srs_pkg::srs_state_t st_ff;
   srs_pkg::srs_state_t nxt_st;

   logic       in_run;
   logic       wr_status;
   logic       win_on;
   logic       svc_bad;
   logic       c_lvr;
   logic       c_wdg;
   logic       c_illegal_opcode_flag;
   logic       c_force;
   logic [7:0] cause;

   // reset causes seen while running
   assign in_run    = (st_ff.phase == srs_pkg::SRS_RUN);
   assign wr_status = cpu_wr && (cpu_sel == srs_pkg::IDX_STATUS);
   assign win_on    = st_ff.opt2[srs_pkg::O2_WIN] && st_ff.opt2[srs_pkg::O2_CLK];
   assign svc_bad   = wr_status && watchdog_enable_bit
                      && ((win_on && !wdog_late)
                          || ((cpu_wdata != srs_pkg::SVC_FIRST)
                              && (cpu_wdata != srs_pkg::SVC_SECOND)));
   assign c_lvr     = lvd_detect && lowvolt_reset_enable;
   assign c_wdg     = (wdog_timeout && watchdog_enable_bit) || svc_bad;
   assign c_illegal_opcode_flag    = illegal_opcode || (stop_exec && !st_ff.opt1[srs_pkg::O1_STOP]);
   assign c_force   = dbg_wr && dbg_wdata[srs_pkg::FORCE_BIT];

   // cause flags captured on reset entry; a forced reset contributes none
   always_comb begin
      cause = 8'h00;
      cause[srs_pkg::ST_PIN]  = !rst_pin_n;
      cause[srs_pkg::ST_WDG]  = c_wdg;
      cause[srs_pkg::ST_ILLEGAL_OPCODE_FLAG] = c_illegal_opcode_flag;
      cause[srs_pkg::ST_ILLEGAL_ADDRESS_FLAG] = illegal_addr;
      cause[srs_pkg::ST_LVD]  = c_lvr;
      cause[srs_pkg::ST_POR]  = c_lvr && st_ff.status[srs_pkg::ST_POR];
   end

   // next state
   always_comb begin
      nxt_st = st_ff;
      nxt_st.wdog_clr = 1'b0;
      nxt_st.stop_go  = 1'b0;
      nxt_st.trip     = lowvolt_trip_select;
      // warning flag: a new warning wins over the acknowledge
      if (warn_ack && !lvw_detect)
         nxt_st.warn = 1'b0;
      if (lvw_detect && lowvolt_warn_irq_enable)
         nxt_st.warn = 1'b1;
      nxt_st.irq = nxt_st.warn && lowvolt_warn_irq_enable;
      // read data; force register always reads zero
      if (cpu_rd) begin
         unique case (cpu_sel)
            srs_pkg::IDX_STATUS: nxt_st.rdata = st_ff.status;
            srs_pkg::IDX_FORCE:  nxt_st.rdata = 8'h00;
            srs_pkg::IDX_OPT1:   nxt_st.rdata = st_ff.opt1;
            srs_pkg::IDX_OPT2:   nxt_st.rdata = st_ff.opt2;
         endcase
      end
      unique case (st_ff.phase)
         srs_pkg::SRS_RUN: begin
            if (c_lvr || c_wdg || c_illegal_opcode_flag || illegal_addr || !rst_pin_n || c_force) begin
               // enter reset; options re-armed to their reset values
               nxt_st.phase     = srs_pkg::SRS_HOLD;
               nxt_st.hold_cnt  = 8'h00;
               nxt_st.sys_rst   = 1'b1;
               nxt_st.lv_hold   = c_lvr;
               nxt_st.status    = cause;
               nxt_st.opt1      = srs_pkg::OPT1_RST;
               nxt_st.opt2      = srs_pkg::OPT2_RST;
               nxt_st.opt1_lock = 1'b0;
               nxt_st.opt2_lock = 1'b0;
               nxt_st.armed     = 1'b0;
            end else begin
               nxt_st.stop_go = stop_exec;
               // watchdog service sequence; status stays untouched
               if (wr_status && watchdog_enable_bit) begin
                  if (cpu_wdata == srs_pkg::SVC_FIRST)
                     nxt_st.armed = 1'b1;
                  else if (st_ff.armed) begin
                     nxt_st.wdog_clr = 1'b1;
                     nxt_st.armed    = 1'b0;
                  end
               end
               // first options register: first write only
               if (cpu_wr && cpu_sel == srs_pkg::IDX_OPT1 && !st_ff.opt1_lock) begin
                  nxt_st.opt1      = cpu_wdata & srs_pkg::O1_MASK;
                  nxt_st.opt1_lock = 1'b1;
               end
               // second options register: top two bits write-once
               if (cpu_wr && cpu_sel == srs_pkg::IDX_OPT2) begin
                  nxt_st.opt2 = cpu_wdata & srs_pkg::O2_MASK & ~srs_pkg::O2_ONCE;
                  if (st_ff.opt2_lock)
                     nxt_st.opt2 = nxt_st.opt2 | (st_ff.opt2 & srs_pkg::O2_ONCE);
                  else
                     nxt_st.opt2 = nxt_st.opt2 | (cpu_wdata & srs_pkg::O2_ONCE);
                  nxt_st.opt2_lock = 1'b1;
               end
            end
         end
         srs_pkg::SRS_HOLD: begin
            if (lvd_above)
               nxt_st.lv_hold = 1'b0;
            if (st_ff.hold_cnt != 8'(srs_pkg::HOLD_CYC - 1))
               nxt_st.hold_cnt = st_ff.hold_cnt + 8'h01;
            else if (!st_ff.lv_hold && rst_pin_n) begin
               nxt_st.phase   = srs_pkg::SRS_RUN;
               nxt_st.sys_rst = 1'b0;
            end
         end
      endcase
   end

   // state register; power-on holds reset until the supply is up
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_ff           <= '0;
         st_ff.phase     <= srs_pkg::SRS_HOLD;
         st_ff.lv_hold   <= 1'b1;
         st_ff.status    <= srs_pkg::STATUS_POR;
         st_ff.opt1      <= srs_pkg::OPT1_RST;
         st_ff.opt2      <= srs_pkg::OPT2_RST;
         st_ff.sys_rst   <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // outputs straight from the state register
   assign cpu_rdata                = st_ff.rdata;
   assign sys_reset                = st_ff.sys_rst;
   assign wdog_clear               = st_ff.wdog_clr;
   assign lvd_trip_sel             = st_ff.trip;
   assign lowvolt_warn_flag        = st_ff.warn;
   assign lowvolt_warn_irq         = st_ff.irq;
   assign stop_enter               = st_ff.stop_go;
   assign watchdog_timeout_field   = st_ff.opt1[srs_pkg::O1_TMO_LO +: 2];
   assign stop_allow_bit           = st_ff.opt1[srs_pkg::O1_STOP];
   assign twowire_pin_select       = st_ff.opt1[srs_pkg::O1_TWI];
   assign watchdog_clock_select    = st_ff.opt2[srs_pkg::O2_CLK];
   assign watchdog_window_bit      = st_ff.opt2[srs_pkg::O2_WIN];
   assign comparator_capture_route = st_ff.opt2[srs_pkg::O2_COMPARATOR_CAPTURE_ROUTE];
   assign timer_pin_select         = st_ff.opt2[3:0];

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_lvr;
      in_run && c_lvr |=> sys_reset && st_ff.status[srs_pkg::ST_LVD]
                          && (st_ff.status[srs_pkg::ST_POR] == $past(st_ff.status[srs_pkg::ST_POR]));
   endproperty
   a_lvr: assert property (p_lvr) else $error("low-voltage reset entry wrong");

   property p_lv_hold;
      st_ff.phase == srs_pkg::SRS_HOLD && st_ff.lv_hold && !lvd_above |=> sys_reset;
   endproperty
   a_lv_hold: assert property (p_lv_hold) else $error("released before supply up");

   property p_rsv;
      !st_ff.status[2] && !st_ff.status[0];
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved status bit set");

   property p_warn;
      lvw_detect && lowvolt_warn_irq_enable |=> lowvolt_warn_flag && lowvolt_warn_irq;
   endproperty
   a_warn: assert property (p_warn) else $error("warning not flagged");

   property p_force;
      in_run && c_force && cause == 8'h00 |=> sys_reset && st_ff.status == 8'h00;
   endproperty
   a_force: assert property (p_force) else $error("forced reset left a flag");

   property p_bad_svc;
      in_run && svc_bad |=> sys_reset && st_ff.status[srs_pkg::ST_WDG];
   endproperty
   a_bad_svc: assert property (p_bad_svc) else $error("bad service write missed");

   property p_svc;
      in_run && cause == 8'h00 && !c_force && wr_status && watchdog_enable_bit
      && st_ff.armed && cpu_wdata == srs_pkg::SVC_SECOND
      |=> wdog_clear && $stable(st_ff.status) ##1 !wdog_clear;
   endproperty
   a_svc: assert property (p_svc) else $error("service sequence failed");

   property p_wdg_off;
      in_run && wdog_timeout && !watchdog_enable_bit |=> !st_ff.status[srs_pkg::ST_WDG] || !$rose(sys_reset);
   endproperty
   a_wdg_off: assert property (p_wdg_off) else $error("disabled watchdog reset");

   property p_force_rd;
      cpu_rd && cpu_sel == srs_pkg::IDX_FORCE |=> cpu_rdata == 8'h00;
   endproperty
   a_force_rd: assert property (p_force_rd) else $error("force register read nonzero");

   property p_opt1_once;
      in_run && st_ff.opt1_lock && !sys_reset ##1 in_run |-> $stable(st_ff.opt1);
   endproperty
   a_opt1_once: assert property (p_opt1_once) else $error("options rewritten");

   property p_stop;
      in_run && stop_exec && !stop_allow_bit |=> sys_reset && st_ff.status[srs_pkg::ST_ILLEGAL_OPCODE_FLAG];
   endproperty
   a_stop: assert property (p_stop) else $error("stop without allow not trapped");

   property p_pin;
      in_run && !rst_pin_n |=> sys_reset && st_ff.status[srs_pkg::ST_PIN] [*2];
   endproperty
   a_pin: assert property (p_pin) else $error("pin reset missed");

   // enabled watchdog timeout resets and flags
   property p_wdg;
      in_run && wdog_timeout && watchdog_enable_bit |=> sys_reset && st_ff.status[srs_pkg::ST_WDG];
   endproperty
   a_wdg: assert property (p_wdg) else $error("watchdog timeout reset missed");

   property p_illegal_address_flag;
      in_run && illegal_addr |=> sys_reset && st_ff.status[srs_pkg::ST_ILLEGAL_ADDRESS_FLAG];
   endproperty
   a_illegal_address_flag: assert property (p_illegal_address_flag) else $error("illegal address reset missed");

   // reset stands while the pin is held low
   property p_pin_hold;
      sys_reset && !rst_pin_n |=> sys_reset;
   endproperty
   a_pin_hold: assert property (p_pin_hold) else $error("released while pin low");

   // user writes to the force register never reset
   property p_force_user;
      in_run && cpu_wr && cpu_sel == srs_pkg::IDX_FORCE && !dbg_wr && cause == 8'h00 |=> !sys_reset;
   endproperty
   a_force_user: assert property (p_force_user) else $error("user force write reset");

   // status changes only on reset entry
   property p_status_ro;
      in_run ##1 in_run |-> $stable(st_ff.status);
   endproperty
   a_status_ro: assert property (p_status_ro) else $error("status changed while running");

   // write-once bits of the second options register keep their value
   property p_opt2_once;
      in_run && st_ff.opt2_lock ##1 in_run
      |-> (st_ff.opt2 & srs_pkg::O2_ONCE) == ($past(st_ff.opt2) & srs_pkg::O2_ONCE);
   endproperty
   a_opt2_once: assert property (p_opt2_once) else $error("write-once option bits changed");

   // trip select follows its control one cycle late
   property p_trip;
      in_run |=> lvd_trip_sel == $past(lowvolt_trip_select);
   endproperty
   a_trip: assert property (p_trip) else $error("trip select not passed on");

   // warning flag holds until acknowledged
   property p_warn_keep;
      lowvolt_warn_flag && !warn_ack |=> lowvolt_warn_flag;
   endproperty
   a_warn_keep: assert property (p_warn_keep) else $error("warning flag lost");

   // reset entry returns the first options register to its reset value
   property p_opt_rearm;
      in_run && (c_lvr || c_wdg || c_illegal_opcode_flag || illegal_addr || !rst_pin_n || c_force)
      |=> st_ff.opt1 == srs_pkg::OPT1_RST && !st_ff.opt1_lock;
   endproperty
   a_opt_rearm: assert property (p_opt_rearm) else $error("options not re-armed on reset");

   // main scenarios
   c_svc:   cover property (in_run ##1 wdog_clear);
   c_lvrel: cover property (sys_reset && st_ff.lv_hold ##[1:40] !sys_reset);
   c_force_c: cover property (in_run && c_force ##1 st_ff.status == 8'h00);
   c_pin_c: cover property (in_run && !rst_pin_n ##1 st_ff.status == 8'h40);
   c_win_c: cover property (in_run && win_on && svc_bad);

endmodule

// file: testbench/srs_host_model.sv
// cpu software and background debug host model driving the register port
`timescale 1ns/1ps
module srs_host_model (
   // clock
   input  wire logic       clk_sys,
   // cpu register port
   output logic      [1:0] cpu_sel,
   output logic            cpu_wr,
   output logic            cpu_rd,
   output logic      [7:0] cpu_wdata,
   input  wire logic [7:0] cpu_rdata,
   // background debug write
   output logic            dbg_wr,
   output logic      [7:0] dbg_wdata
);
   // quiet bus at time zero
   initial begin
      cpu_sel   = 2'h0;
      cpu_wr    = 1'b0;
      cpu_rd    = 1'b0;
      cpu_wdata = 8'h00;
      dbg_wr    = 1'b0;
      dbg_wdata = 8'h00;
   end
   // one cpu write then an idle cycle; data lines are then driven to the inverted value
   task automatic wr(input logic [1:0] sel, input logic [7:0] d);
      cpu_sel   <= sel;
      cpu_wdata <= d;
      cpu_wr    <= 1'b1;
      @(posedge clk_sys);
      cpu_wr    <= 1'b0;
      cpu_wdata <= ~d;
      @(posedge clk_sys);
   endtask
   // one cpu read, data taken once it is registered
   task automatic rd(input logic [1:0] sel, output logic [7:0] d);
      cpu_sel <= sel;
      cpu_rd  <= 1'b1;
      @(posedge clk_sys);
      cpu_rd  <= 1'b0;
      @(posedge clk_sys);
      d = cpu_rdata;
   endtask
   // watchdog service pair written back to back
   task automatic service();
      cpu_sel   <= srs_pkg::IDX_STATUS;
      cpu_wdata <= srs_pkg::SVC_FIRST;
      cpu_wr    <= 1'b1;
      @(posedge clk_sys);
      cpu_wdata <= srs_pkg::SVC_SECOND;
      @(posedge clk_sys);
      cpu_wr    <= 1'b0;
      cpu_wdata <= 8'h55;
      @(posedge clk_sys);
   endtask
   // background command setting the force bit
   task automatic dbg_force();
      dbg_wdata <= 8'h01;
      dbg_wr    <= 1'b1;
      @(posedge clk_sys);
      dbg_wr    <= 1'b0;
      dbg_wdata <= 8'hFE;
      @(posedge clk_sys);
   endtask
endmodule

// file: testbench/test_srs_reset_status.sv
// self-checking bench of the reset status and option block
`timescale 1ns/1ps
module test_srs_reset_status;
   logic       clk_sys, rstn, cpu_wr, cpu_rd, dbg_wr, sys_reset, wdog_clear, lvd_trip_sel;
   logic       lvd_above, lowvolt_reset_enable, lowvolt_trip_select, lowvolt_warn_irq_enable;
   logic       lvw_detect, warn_ack, watchdog_enable_bit, wdog_late, lowvolt_warn_flag, lowvolt_warn_irq;
   logic       stop_enter, stop_allow_bit, twowire_pin_select, watchdog_clock_select, watchdog_window_bit;
   logic       comparator_capture_route, rst_pin_n, lvd_detect, wdog_timeout, illegal_opcode;
   logic       illegal_addr, stop_exec;
   logic [1:0] cpu_sel, watchdog_timeout_field;
   logic [3:0] timer_pin_select;
   logic [5:0] cv;
   logic [7:0] cpu_wdata, cpu_rdata, dbg_wdata, v1, v2, e2;
   int         error_cnt, checks_done, clr_cnt, stop_cnt, seed, n;
   // reset causes driven from one vector, pin active low
   assign lvd_detect     = cv[0];
   assign rst_pin_n      = ~cv[1];
   assign wdog_timeout   = cv[2];
   assign illegal_opcode = cv[3];
   assign illegal_addr   = cv[4];
   assign stop_exec      = cv[5];
   srs_reset_status dut (.clk_sys, .rstn, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .dbg_wr,
      .dbg_wdata, .rst_pin_n, .lvd_detect, .lvd_above, .illegal_opcode, .illegal_addr, .stop_exec,
      .lowvolt_reset_enable, .lowvolt_trip_select, .lowvolt_warn_irq_enable, .lvw_detect, .warn_ack,
      .watchdog_enable_bit, .wdog_timeout, .wdog_late, .sys_reset, .wdog_clear, .lvd_trip_sel,
      .lowvolt_warn_flag, .lowvolt_warn_irq, .stop_enter, .watchdog_timeout_field, .stop_allow_bit,
      .twowire_pin_select, .watchdog_clock_select, .watchdog_window_bit, .comparator_capture_route,
      .timer_pin_select);
   srs_host_model host (.clk_sys, .cpu_sel, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .dbg_wr, .dbg_wdata);
   // clock and pulse counters
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (wdog_clear === 1'b1) clr_cnt++;
      if (stop_enter === 1'b1) stop_cnt++;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input string what, input logic [1:0] sel, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(sel, d);
      chk(what, exp, d);
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // wait a bounded time for the system reset to fall
   task automatic wait_run(input int lim);
      for (int i = 0; i < lim && sys_reset !== 1'b0; i++) @(posedge clk_sys);
      chk("sys_reset low", 8'h00, {7'h0, sys_reset});
   endtask
   // one reset cause (or a refused one), then the status it leaves behind
   task automatic run_case(input int kind, input logic [7:0] exp, input logic rst);
      logic [7:0] d;
      d = 8'($random(seed));
      if (d == 8'h55 || d == 8'hAA) d = 8'h00;
      watchdog_enable_bit  <= (kind != 9);
      lowvolt_reset_enable <= (kind != 11);
      wdog_late            <= 1'b0;
      if (kind < 6 || kind >= 9 && kind != 10) begin
         cv <= 6'h01 << (kind == 9 ? 2 : kind == 11 ? 0 : kind);
         if (kind == 0) lvd_above <= 1'b0;
         @(posedge clk_sys);
         cv <= 6'h00;
      end else if (kind == 6) host.dbg_force();
      else if (kind == 7) host.wr(srs_pkg::IDX_STATUS, d);
      else if (kind == 10) host.wr(srs_pkg::IDX_FORCE, 8'h01);
      else begin
         host.wr(srs_pkg::IDX_OPT2, 8'hC0);
         host.wr(srs_pkg::IDX_STATUS, srs_pkg::SVC_FIRST);
      end
      repeat (4) @(posedge clk_sys);
      chk("sys_reset", {7'h0, rst}, {7'h0, sys_reset});
      if (kind == 0) begin
         repeat (30) @(posedge clk_sys);
         chk("lv hold", 8'h01, {7'h0, sys_reset});
         lvd_above <= 1'b1;
      end
      wait_run(40);
      rd_chk("status", srs_pkg::IDX_STATUS, exp);
   endtask
   // main sequence
   initial begin
      {clk_sys, rstn, cv, lowvolt_trip_select, lowvolt_warn_irq_enable, lvw_detect, warn_ack} = '0;
      {lvd_above, lowvolt_reset_enable, watchdog_enable_bit, wdog_late} = 4'hF;
      {error_cnt, checks_done, clr_cnt, stop_cnt} = '0;
      seed = 53;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      wait_run(60);
      rd_chk("status por", srs_pkg::IDX_STATUS, 8'h82);
      rd_chk("force reads", srs_pkg::IDX_FORCE, 8'h00);
      rd_chk("opt1 reset", srs_pkg::IDX_OPT1, 8'h00);
      rd_chk("opt2 reset", srs_pkg::IDX_OPT2, 8'h00);
      v1 = 8'($random(seed));
      v1[5] = 1'b1;
      v2 = 8'($random(seed));
      e2 = (v2 & 8'hC0) | (~v2 & 8'h1F);
      host.wr(srs_pkg::IDX_OPT1, v1);
      host.wr(srs_pkg::IDX_OPT1, ~v1);
      host.wr(srs_pkg::IDX_OPT2, v2);
      host.wr(srs_pkg::IDX_OPT2, ~v2);
      rd_chk("opt1", srs_pkg::IDX_OPT1, v1 & 8'hE4);
      chk("opt1 out", v1 & 8'hE4, {watchdog_timeout_field, stop_allow_bit, 2'h0, twowire_pin_select, 2'h0});
      rd_chk("opt2", srs_pkg::IDX_OPT2, e2);
      chk("opt2 out", e2, {watchdog_clock_select, watchdog_window_bit, 1'b0, comparator_capture_route,
         timer_pin_select});
      wdog_late <= 1'b1;
      n = clr_cnt;
      host.service();
      host.wr(srs_pkg::IDX_STATUS, srs_pkg::SVC_SECOND);
      chk("service clears", 8'h01, 8'(clr_cnt - n));
      rd_chk("status kept", srs_pkg::IDX_STATUS, 8'h82);
      cv <= 6'h20;
      lowvolt_trip_select <= v2[0];
      @(posedge clk_sys);
      cv <= 6'h00;
      repeat (3) @(posedge clk_sys);
      chk("stop allowed", 8'h01, {7'h0, sys_reset === 1'b0 && stop_cnt == 1});
      chk("trip select", {7'h0, v2[0]}, {7'h0, lvd_trip_sel});
      lowvolt_warn_irq_enable <= 1'b1;
      lvw_detect <= 1'b1;
      @(posedge clk_sys);
      lvw_detect <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("warning", 8'h03, {6'h0, lowvolt_warn_flag, lowvolt_warn_irq});
      warn_ack <= 1'b1;
      @(posedge clk_sys);
      warn_ack <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("warning acked", 8'h00, {6'h0, lowvolt_warn_flag, lowvolt_warn_irq});
      run_case(0, 8'h82, 1'b1);
      run_case(1, 8'h40, 1'b1);
      run_case(0, 8'h02, 1'b1);
      run_case(2, 8'h20, 1'b1);
      run_case(3, 8'h10, 1'b1);
      run_case(5, 8'h10, 1'b1);
      run_case(4, 8'h08, 1'b1);
      run_case(7, 8'h20, 1'b1);
      run_case(8, 8'h20, 1'b1);
      run_case(6, 8'h00, 1'b1);
      run_case(9, 8'h00, 1'b0);
      run_case(10, 8'h00, 1'b0);
      run_case(11, 8'h00, 1'b0);
      // power-on reset again in mid-run; flags and options start over
      host.wr(srs_pkg::IDX_OPT2, 8'h1F);
      rstn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      wait_run(60);
      rd_chk("status por again", srs_pkg::IDX_STATUS, 8'h82);
      rd_chk("opt2 por again", srs_pkg::IDX_OPT2, 8'h00);
      give_verdict();
   end
   // watchdog against a hang
   initial begin
      #80000;
      error_cnt++;
      give_verdict();
   end
endmodule
